//--- hw/dma_arbiter.sv
// Two-channel transfer controller: device handshake, bus arbitration and a byte register port.
// Assumes pins arrive asynchronous, the internal CPU grant and register port run on i_clk.
//
// Contract
// - Two channels move byte or word operands for 8- or 16-bit device ports.
// - Each channel runs cycle-steal (one operand per bus tenure) or burst.
// - Channel 1 single addressing only; channel 2 single or dual addressing.
// - The serving channel drives its acknowledge low during each device transfer; the code keeps channel 2's acknowledge high in dual addressing.
// - Transfer-complete pulses low when a device bus cycle finishes.
// - Done is driven low when the memory transfer count is exhausted.
// - Done driven low by a device ends the operation after the current operand.
// - Priority: channel 1, channel 2, external masters, then the CPU.
// - Raise internal bus request; withhold grant from external masters meanwhile.
// - If external masters already own the bus, wait until grant-acknowledge deasserts.
// - The CPU finishes its present cycle before passing the grant.
// - After grant, take the bus only when address strobe and acknowledge are inactive.
// - No external grant while grant-acknowledge shows another owner.
// - Reserved locations read all ones with a normal cycle.
// - Every register is reachable as a byte.
// - Unused compatibility bits read their fixed default regardless of writes.
// - Address bits 7:6 select channel: 00 channel 1, 01 channel 2, others reserved.
// - Device control bit 15 selects burst (0) or cycle-steal (1).
`timescale 1ns/1ps

module dma_arbiter
	import dma_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_chan1_request_n,
	input  wire logic        i_chan2_request_n,
	output logic             o_chan1_acknowledge_n,
	output logic             o_chan2_acknowledge_n,
	input  wire logic        i_device_ready_n,
	output logic             o_transfer_complete_n,
	input  wire logic        i_transfer_done_n,
	output logic             o_transfer_done_n,
	output logic             o_transfer_done_oe,
	input  wire logic [15:0] i_dev_data,
	input  wire logic        i_cpu_grant_n,
	output logic             o_int_bus_request_n,
	input  wire logic        i_bus_request_n,
	output logic             o_bus_grant_n,
	input  wire logic        i_bus_grant_ack_n,
	output logic             o_bus_owner,
	input  wire logic        i_address_strobe_n,
	input  wire logic        i_data_transfer_ack_n,
	output logic [15:0]      o_mem_data,
	output logic             o_mem_valid,
	input  wire logic        i_mem_ready,
	input  wire logic        i_reg_req,
	input  wire logic        i_reg_we,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic [7:0]       o_reg_rdata,
	output logic             o_reg_done
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: the first stage feeds only the second.
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	wire  [7:0] pins = {i_chan1_request_n, i_chan2_request_n, i_device_ready_n, i_transfer_done_n,
	                    i_bus_request_n, i_bus_grant_ack_n, i_address_strobe_n, i_data_transfer_ack_n};

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_q <= 8'hff;
			sync2_q <= 8'hff;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
		end
	end

	wire req1_s  = !sync2_q[7];
	wire req2_s  = !sync2_q[6];
	wire rdy_s   = !sync2_q[5];
	wire done_s  = !sync2_q[4];
	wire xreq_s  = !sync2_q[3];
	wire bgack_s = !sync2_q[2];
	wire as_s    = !sync2_q[1];
	wire dack_s  = !sync2_q[0];

	// Device data is registered every cycle but only used while ready, or in dual addressing acknowledge, already stands synchronised, so it is settled then.
	logic [15:0] dev_data_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			dev_data_q <= 16'h0000;
		end else begin
			dev_data_q <= i_dev_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel programmable state.
	logic [15:0] dcr_q [2];
	logic [15:0] mtc_q [2];
	logic [1:0]  start_q;

	// Stored device control with fixed fields forced; channel 1 is always implicitly addressed.
	function automatic word_t dcr_view(input logic ch, input word_t raw);
		word_t v;
		v = raw & `DCR_STORE_MASK;
		if (!ch) begin
			v[`DCR_DTYPE_HI:`DCR_DTYPE_LO] = `DTYPE_IMPLICIT;
		end
		return v;
	endfunction

	// Register read decode for one channel's byte offset.
	function automatic byte_t reg_read(input logic ch, input logic [5:0] off);
		word_t d;
		d = dcr_view(ch, dcr_q[ch]);
		unique case (off)
			`OFF_DCR_HI: reg_read = d[15:8];
			`OFF_DCR_LO: reg_read = d[7:0];
			`OFF_CCR:    reg_read = `CCR_DEFAULT | {start_q[ch], 7'h00};
			`OFF_MTC_HI: reg_read = mtc_q[ch][15:8];
			`OFF_MTC_LO: reg_read = mtc_q[ch][7:0];
			`OFF_CPR:    reg_read = `CPR_DEFAULT;
			default:     reg_read = `NULL_DATA;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register port decode: byte wide, channel in bits 7:6.
	wire [1:0] reg_sel   = i_reg_addr[7:6];
	wire [5:0] reg_off   = i_reg_addr[5:0];
	wire       reg_ch    = reg_sel[0];
	wire       reg_chok  = (reg_sel == `CHSEL_CHAN1) || (reg_sel == `CHSEL_CHAN2);
	wire       reg_wr    = i_reg_req && i_reg_we && reg_chok;
	wire       wr_dcr_hi = reg_wr && (reg_off == `OFF_DCR_HI);
	wire       wr_dcr_lo = reg_wr && (reg_off == `OFF_DCR_LO);
	wire       wr_ccr    = reg_wr && (reg_off == `OFF_CCR);
	wire       wr_mtc_hi = reg_wr && (reg_off == `OFF_MTC_HI);
	wire       wr_mtc_lo = reg_wr && (reg_off == `OFF_MTC_LO);
	wire [7:0] rd_byte   = reg_chok ? reg_read(reg_ch, reg_off) : `NULL_DATA;

	// Every access, mapped or not, answers one cycle later as a normal cycle.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_reg_rdata <= 8'h00;
			o_reg_done  <= 1'b0;
		end else begin
			o_reg_rdata <= (i_reg_req && !i_reg_we) ? rd_byte : o_reg_rdata;
			o_reg_done  <= i_reg_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer sequence signals.
	dma_state_t state_q;
	dma_state_t state_d;
	logic       ch_q;
	logic       done_in_q;
	wire        fifo_wready;
	wire [1:0]  pend      = {req2_s && start_q[1] && (mtc_q[1] != `MTC_RESET),
	                         req1_s && start_q[0] && (mtc_q[0] != `MTC_RESET)};
	wire        pick      = !pend[0];
	wire [15:0] act_dcr   = dcr_view(ch_q, dcr_q[ch_q]);
	wire        cyc_steal = act_dcr[`DCR_MODE_BIT];
	wire        dual_addr = ch_q && (act_dcr[`DCR_DTYPE_HI:`DCR_DTYPE_LO] == `DTYPE_EXPLICIT);
	wire        port16    = act_dcr[`DCR_SIZE_BIT];
	wire        handshake = dual_addr ? dack_s : rdy_s;
	wire        xfer_go   = (state_q == ST_XFER) && handshake && fifo_wready;
	wire        last_op   = (mtc_q[ch_q] == `MTC_ONE);
	// In the end state the counter has already been decremented, so exhaustion reads as zero there.
	wire        cnt_out   = (mtc_q[ch_q] == `MTC_RESET);
	wire        finish    = cnt_out || done_in_q || done_s;
	wire        more      = pend[ch_q] && !cyc_steal && !(pend[0] && ch_q);
	wire [15:0] operand   = port16 ? dev_data_q : {8'h00, dev_data_q[7:0]};

	// Next state of the arbitration and transfer sequence.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:     if (pend != 2'b00) state_d = bgack_s ? ST_WAIT_EXT : ST_REQ;
			ST_WAIT_EXT: if (!bgack_s) state_d = ST_REQ;
			ST_REQ:      if (!i_cpu_grant_n) state_d = ST_WAIT_BUS;
			ST_WAIT_BUS: if (!as_s && !dack_s) state_d = ST_XFER;
			ST_XFER:     if (xfer_go) state_d = ST_END;
			ST_END:      state_d = (!finish && more) ? ST_WAIT_BUS : ST_IDLE;
		endcase
	end

	// State and channel choice; the channel is latched only when leaving idle.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			ch_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			ch_q    <= (state_q == ST_IDLE && pend != 2'b00) ? pick : ch_q;
		end
	end

	// A done input seen during a tenure is remembered until the operand completes.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			done_in_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			done_in_q <= 1'b0;
		end else if (done_s) begin
			done_in_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counters, control and start bits; hardware end of channel clears start unless software sets it.
	wire       ch_end = (state_q == ST_END) && finish;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			dcr_q   <= '{`DCR_RESET, `DCR_RESET};
			mtc_q   <= '{`MTC_RESET, `MTC_RESET};
			start_q <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (wr_dcr_hi && reg_ch == c[0]) dcr_q[c][15:8] <= i_reg_wdata & 8'(`DCR_STORE_MASK >> 8);
				if (wr_dcr_lo && reg_ch == c[0]) dcr_q[c][7:0]  <= i_reg_wdata & 8'(`DCR_STORE_MASK);
				if (wr_mtc_hi && reg_ch == c[0]) mtc_q[c][15:8] <= i_reg_wdata;
				else if (wr_mtc_lo && reg_ch == c[0]) mtc_q[c][7:0] <= i_reg_wdata;
				else if (xfer_go && ch_q == c[0]) mtc_q[c] <= mtc_q[c] - `MTC_ONE;
				if (wr_ccr && reg_ch == c[0]) start_q[c] <= i_reg_wdata[`CCR_START_BIT];
				else if (ch_end && ch_q == c[0]) start_q[c] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin outputs, all from flip-flops.
	// Waiting for the bus keeps ownership only when a burst already holds it; a fresh tenure must wait.
	wire own_next = (state_d == ST_XFER) || (state_d == ST_END) || (state_d == ST_WAIT_BUS && o_bus_owner);
	wire want_bus = (state_d != ST_IDLE) || (pend != 2'b00);
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_chan1_acknowledge_n <= 1'b1;
			o_chan2_acknowledge_n <= 1'b1;
			o_transfer_complete_n <= 1'b1;
			o_transfer_done_n     <= 1'b1;
			o_transfer_done_oe    <= 1'b0;
			o_int_bus_request_n   <= 1'b1;
			o_bus_grant_n         <= 1'b1;
			o_bus_owner           <= 1'b0;
		end else begin
			o_chan1_acknowledge_n <= !(state_d == ST_XFER && !ch_q);
			o_chan2_acknowledge_n <= !(state_d == ST_XFER && ch_q && !dual_addr);
			o_transfer_complete_n <= !xfer_go;
			o_transfer_done_n     <= !(xfer_go && last_op);
			o_transfer_done_oe    <= xfer_go && last_op;
			o_int_bus_request_n   <= !(want_bus && state_d != ST_WAIT_EXT);
			o_bus_grant_n         <= !(xreq_s && !want_bus && !bgack_s && !i_cpu_grant_n);
			o_bus_owner           <= own_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand buffer toward the memory side; a full buffer stalls the device handshake.
	dma_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.PTR_W (`FIFO_PTR_W)
	) u_fifo (
		.i_clk    (i_clk),
		.i_nrst   (i_nrst),
		.i_wdata  (operand),
		.i_wvalid (xfer_go),
		.o_wready (fifo_wready),
		.o_rdata  (o_mem_data),
		.o_rvalid (o_mem_valid),
		.i_rready (i_mem_ready)
	);

endmodule // dma_arbiter

//--- hw/dma_consts.svh
// Named constants of the two-channel transfer controller: register map, field positions, reset values.
// Assumes inclusion by its bare name from the package only; the design modules use its macros without including it.
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH

// Channel select field, the top two bits of a register address.
`define CHSEL_CHAN1      2'b00
`define CHSEL_CHAN2      2'b01

// Byte offsets inside one channel's register set.
`define OFF_DCR_HI       6'h04
`define OFF_DCR_LO       6'h05
`define OFF_CCR          6'h07
`define OFF_MTC_HI       6'h0a
`define OFF_MTC_LO       6'h0b
`define OFF_CPR          6'h2d

// Read value of every reserved location.
`define NULL_DATA        8'hff

// Device control register fields.
`define DCR_MODE_BIT     15
`define DCR_DTYPE_HI     13
`define DCR_DTYPE_LO     12
`define DCR_SIZE_BIT     11
`define DCR_STORE_MASK   16'hb800
`define DCR_RESET        16'h0000
`define DTYPE_IMPLICIT   2'b11
`define DTYPE_EXPLICIT   2'b00

// Channel control register: start bit, other bits read as their fixed default.
`define CCR_START_BIT    7
`define CCR_DEFAULT      8'h00

// Compatibility-only priority register default.
`define CPR_DEFAULT      8'h00

// Counter constants.
`define MTC_RESET        16'h0000
`define MTC_ONE          16'h0001

// Data buffer shape.
`define FIFO_WIDTH       16
`define FIFO_DEPTH       4
`define FIFO_PTR_W       2

`endif

//--- hw/dma_pkg.sv
// Types shared by the transfer controller modules.
// Assumes dma_consts.svh is reachable on the include path.
`include "dma_consts.svh"

package dma_pkg;

	// Bus arbitration and transfer sequence of the active channel.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_EXT,
		ST_REQ,
		ST_WAIT_BUS,
		ST_XFER,
		ST_END
	} dma_state_t;

	typedef logic [15:0] word_t;
	typedef logic [7:0]  byte_t;

endpackage

//--- hw/dma_fifo.sv
// Small synchronous FIFO with registered read data and valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset shared with its user.
`timescale 1ns/1ps

module dma_fifo #(
	parameter int WIDTH = `FIFO_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH,
	parameter int PTR_W = `FIFO_PTR_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic             i_wvalid,
	output logic                  o_wready,
	output logic [WIDTH-1:0]      o_rdata,
	output logic                  o_rvalid,
	input  wire logic             i_rready
);

	////////////////////////////////////////////////////////////////////////////////
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wptr_q;
	logic [PTR_W-1:0] rptr_q;
	logic [PTR_W:0]   count_q;
	logic [PTR_W:0]   count_d;
	wire              push;
	wire              pop;
	wire              full;
	wire              empty;

	// The output stage counts as one slot so that full is exact across the register.
	assign full     = (count_q == (PTR_W+1)'(DEPTH));
	assign empty    = (count_q == '0);
	assign push     = i_wvalid && !full;
	assign pop      = o_rvalid && i_rready;
	assign o_wready = !full;
	assign count_d  = count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

	// Storage array; no reset needed on data.
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wptr_q] <= i_wdata;
		end
	end

	// Write pointer and occupancy.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wptr_q  <= '0;
			count_q <= '0;
		end else begin
			wptr_q  <= push ? wptr_q + 1'b1 : wptr_q;
			count_q <= count_d;
		end
	end

	// Registered read port: refill the output word when it is empty or being taken.
	wire load = (!o_rvalid || i_rready) && (count_q > (PTR_W+1)'(o_rvalid));
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rptr_q   <= '0;
			o_rvalid <= 1'b0;
			o_rdata  <= '0;
		end else begin
			if (load) begin
				o_rdata <= mem_q[rptr_q];
				rptr_q  <= rptr_q + 1'b1;
			end
			o_rvalid <= load ? 1'b1 : (o_rvalid && !i_rready);
		end
	end

endmodule // dma_fifo

//--- verification/dma_arbiter_monitor.sv
// Checker of the transfer controller, watching only its top-level ports.
// Assumes one clock and an asynchronous active-low reset; bound to every dma_arbiter.
`timescale 1ns/1ps

module dma_arbiter_monitor (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        o_chan1_acknowledge_n,
	input  wire logic        o_chan2_acknowledge_n,
	input  wire logic        o_transfer_complete_n,
	input  wire logic        o_transfer_done_n,
	input  wire logic        o_transfer_done_oe,
	input  wire logic        o_int_bus_request_n,
	input  wire logic        o_bus_grant_n,
	input  wire logic        o_bus_owner,
	input  wire logic [15:0] o_mem_data,
	input  wire logic        o_mem_valid,
	input  wire logic        i_mem_ready,
	input  wire logic        i_reg_req,
	input  wire logic        i_reg_we,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  o_reg_rdata,
	input  wire logic        o_reg_done
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	// Decoded helpers shared by several properties.
	wire logic ack_any = !o_chan1_acknowledge_n || !o_chan2_acknowledge_n;
	wire logic rd_req  = i_reg_req && !i_reg_we;

	////////////////////////////////////////////////////////////////////////////////
	// Device handshake: one channel at a time, and only while it owns the bus.
	property p_ack_one; !(!o_chan1_acknowledge_n && !o_chan2_acknowledge_n); endproperty
	a_ack_one: assert property (p_ack_one) else $error("both acknowledges low");
	property p_ack_own; ack_any |-> o_bus_owner; endproperty
	a_ack_own: assert property (p_ack_own) else $error("acknowledge without bus");
	property p_cpl_src; !o_transfer_complete_n |-> o_bus_owner && $past(o_bus_owner); endproperty
	a_cpl_src: assert property (p_cpl_src) else $error("complete outside a transfer");
	property p_cpl_one; !o_transfer_complete_n |=> o_transfer_complete_n; endproperty
	a_cpl_one: assert property (p_cpl_one) else $error("complete longer than a cycle");
	property p_done_last; o_transfer_done_oe |-> !o_transfer_done_n && !o_transfer_complete_n; endproperty
	a_done_last: assert property (p_done_last) else $error("done out of step");
	property p_done_one; o_transfer_done_oe |=> !o_transfer_done_oe; endproperty
	a_done_one: assert property (p_done_one) else $error("done held too long");

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration, register port and buffer output.
	property p_grant; !o_bus_grant_n |-> o_int_bus_request_n && !o_bus_owner; endproperty
	a_grant: assert property (p_grant) else $error("external grant while own request");
	property p_reg_ans; i_reg_req |=> o_reg_done; endproperty
	a_reg_ans: assert property (p_reg_ans) else $error("register access not answered");
	property p_null; rd_req && i_reg_addr[7] |=> o_reg_rdata == 8'hff; endproperty
	a_null: assert property (p_null) else $error("reserved channel read not all ones");
	property p_cpr; rd_req && !i_reg_addr[7] && i_reg_addr[5:0] == 6'h2d |=> o_reg_rdata == 8'h00; endproperty
	a_cpr: assert property (p_cpr) else $error("compatibility register not default");
	property p_hold; o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_data); endproperty
	a_hold: assert property (p_hold) else $error("buffer output dropped a word");

	// Main scenarios reached.
	c_ack1: cover property (!o_chan1_acknowledge_n);
	c_ack2: cover property (!o_chan2_acknowledge_n);
	c_done: cover property (o_transfer_done_oe);
	c_stall: cover property (o_mem_valid && !i_mem_ready);
endmodule // dma_arbiter_monitor

bind dma_arbiter dma_arbiter_monitor i_mon (.*);

//--- verification/dma_device_model.sv
// Peripheral device model for one channel: request, ready handshake and data.
// Assumes it is stepped on the falling edge so its pins settle before rising edges.
`timescale 1ns/1ps

module dma_device_model #(
	parameter int          WAIT = 0,
	parameter logic [15:0] BASE = 16'h0000
) (
	input  wire logic        i_clk,
	input  wire logic        i_go,
	input  wire logic        i_ack_n,
	input  wire logic        i_cpl_n,
	output logic             o_req_n,
	output logic             o_rdy_n,
	output logic [15:0]      o_data
);
	logic [15:0] data_q = BASE;
	int          cnt_q  = 0;

	initial begin
		o_req_n = 1'b1;
		o_rdy_n = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Ready follows our own acknowledge after WAIT cycles, so a slow device is possible.
	always @(negedge i_clk) begin
		o_req_n <= !i_go;
		if (!i_cpl_n && !o_rdy_n) begin
			data_q <= data_q + 16'h0001;
			o_rdy_n <= 1'b1;
			cnt_q <= 0;
		end else if (!i_ack_n) begin
			cnt_q <= cnt_q + 1;
			o_rdy_n <= (cnt_q < WAIT);
		end else begin
			o_rdy_n <= 1'b1;
			cnt_q <= 0;
		end
	end

	// A deselected device drives the inverse of its data, which keeps stale data from passing.
	assign o_data = i_ack_n ? ~data_q : data_q;
endmodule // dma_device_model

//--- verification/tb.sv
// Self-checking bench of the transfer controller with two device models.
// Assumes the package, design, checker and device model are compiled first.
`timescale 1ns/1ps

module tb;
	import dma_pkg::*;
	typedef struct {logic we; byte_t a; byte_t wd; byte_t ex;} row_t;
	logic  i_clk = 0, i_nrst = 0, i_cpu_grant_n = 1, i_bus_request_n = 1, i_bus_grant_ack_n = 1;
	logic  i_address_strobe_n = 1, i_data_transfer_ack_n = 1, i_mem_ready = 1, i_reg_req = 0, i_reg_we = 0;
	logic  i_chan1_request_n, i_chan2_request_n, i_device_ready_n, i_transfer_done_n, rdy1, rdy2;
	logic  o_chan1_acknowledge_n, o_chan2_acknowledge_n, o_transfer_complete_n, o_transfer_done_n;
	logic  o_transfer_done_oe, o_int_bus_request_n, o_bus_grant_n, o_bus_owner, o_mem_valid, o_reg_done;
	logic  go1 = 0, go2 = 0, dev_done_n = 1, own_q = 0;
	byte_t i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata, r;
	word_t i_dev_data, o_mem_data, d1, d2, got[$];
	int    bad_count = 0, checked = 0, ncpl = 0, ndone = 0, nown = 0, first = 0;
	row_t  rows[17] = '{
		'{1, 8'h04, 8'hff, 8'h00}, '{0, 8'h04, 8'h00, 8'hb8}, '{1, 8'h04, 8'h00, 8'h00},
		'{0, 8'h04, 8'h00, 8'h30}, '{1, 8'h44, 8'h00, 8'h00}, '{0, 8'h44, 8'h00, 8'h00},
		'{0, 8'h02, 8'h00, 8'hff}, '{1, 8'h84, 8'hff, 8'h00}, '{0, 8'h84, 8'h00, 8'hff},
		'{0, 8'h04, 8'h00, 8'h30}, '{1, 8'h6d, 8'hff, 8'h00}, '{0, 8'h6d, 8'h00, 8'h00},
		'{1, 8'h0b, 8'h03, 8'h00}, '{0, 8'h0b, 8'h00, 8'h03}, '{0, 8'h0a, 8'h00, 8'h00},
		'{0, 8'hc4, 8'h00, 8'hff}, '{0, 8'h45, 8'h00, 8'h00}};

	dma_arbiter i_dut (.*);
	dma_device_model #(.WAIT(0), .BASE(16'h1000)) i_dev1 (.i_clk(i_clk), .i_go(go1),
		.i_ack_n(o_chan1_acknowledge_n), .i_cpl_n(o_transfer_complete_n), .o_req_n(i_chan1_request_n),
		.o_rdy_n(rdy1), .o_data(d1));
	dma_device_model #(.WAIT(3), .BASE(16'h21a5)) i_dev2 (.i_clk(i_clk), .i_go(go2),
		.i_ack_n(o_chan2_acknowledge_n), .i_cpl_n(o_transfer_complete_n), .o_req_n(i_chan2_request_n),
		.o_rdy_n(rdy2), .o_data(d2));

	////////////////////////////////////////////////////////////////////////////////
	// Shared pins: ready and done are pulled up, so any driver may pull them low.
	assign i_device_ready_n = rdy1 & rdy2;
	assign i_dev_data = o_chan1_acknowledge_n ? d2 : d1;
	assign i_transfer_done_n = dev_done_n & (o_transfer_done_n | !o_transfer_done_oe);
	always #20 i_clk = ~i_clk;
	// The processor hands over the bus once asked, by us or by an external master.
	always @(negedge i_clk) i_cpu_grant_n <= o_int_bus_request_n & i_bus_request_n;

	// Event counters for the transfer scenarios.
	always @(posedge i_clk) begin
		if (!o_transfer_complete_n) ncpl++;
		if (o_transfer_done_oe) ndone++;
		if (o_bus_owner && !own_q) nown++;
		own_q <= o_bus_owner;
		if (o_mem_valid && i_mem_ready) got.push_back(o_mem_data);
		if (first == 0 && !o_chan1_acknowledge_n) first = 1;
		else if (first == 0 && !o_chan2_acknowledge_n) first = 2;
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("counts: checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// One byte register access; the answer comes one cycle after it is taken.
	task automatic rio(input logic we, input byte_t a, input byte_t wd, output byte_t rd);
		@(negedge i_clk);
		i_reg_req = 1;
		i_reg_we = we;
		i_reg_addr = a;
		i_reg_wdata = wd;
		@(negedge i_clk);
		i_reg_req = 0;
		rd = o_reg_rdata;
		chk("reg_done", {15'h0000, o_reg_done}, 16'h0001);
	endtask

	task automatic cfg(input logic [1:0] ch, input byte_t device_control_reg, input byte_t cnt);
		rio(1, {ch, 6'h04}, device_control_reg, r);
		rio(1, {ch, 6'h0b}, cnt, r);
		rio(1, {ch, 6'h07}, 8'h80, r);
	endtask

	// Watchdog sized well above the at most about fifteen hundred cycles the run can take.
	initial begin
		#(40 * 6000);
		bad_count++;
		close_out();
	end

	initial begin
		repeat (3) @(negedge i_clk);
		i_nrst = 1;
		@(negedge i_clk);
		chk("idle", {6'h00, o_chan1_acknowledge_n, o_chan2_acknowledge_n, o_transfer_complete_n,
			o_transfer_done_n, o_int_bus_request_n, o_bus_grant_n, o_transfer_done_oe, o_bus_owner,
			o_mem_valid, o_reg_done}, 16'h03f0);
		for (int k = 0; k < 17; k++) begin
			rio(rows[k].we, rows[k].a, rows[k].wd, r);
			if (!rows[k].we) chk("reg_read", {8'h00, r}, {8'h00, rows[k].ex});
		end
		$display("test registers done");
		// Burst with the memory side stalled: the buffer refuses, then drains in order.
		cfg(2'b00, 8'h38, 8'h06);
		i_mem_ready = 0;
		go1 = 1;
		repeat (80) @(negedge i_clk);
		chk("stalled", {15'h0000, ncpl < 6}, 16'h0001);
		i_mem_ready = 1;
		for (int k = 0; k < 300 && got.size() < 6; k++) @(negedge i_clk);
		go1 = 0;
		chk("words", 16'(got.size()), 16'h0006);
		foreach (got[k]) chk("word", got[k], 16'h1000 + 16'(k));
		chk("done_out", 16'(ndone), 16'h0001);
		$display("test burst done");
		// Cycle steal on an 8-bit port, cut short by the device after the second operand.
		got.delete();
		ncpl = 0;
		nown = 0;
		cfg(2'b01, 8'hb0, 8'h05);
		go2 = 1;
		for (int k = 0; k < 300 && ncpl < 1; k++) @(negedge i_clk);
		for (int k = 0; k < 100 && o_chan2_acknowledge_n; k++) @(negedge i_clk);
		dev_done_n = 0;
		for (int k = 0; k < 100 && ncpl < 2; k++) @(negedge i_clk);
		dev_done_n = 1;
		repeat (60) @(negedge i_clk);
		go2 = 0;
		chk("ended", 16'(ncpl), 16'h0002);
		chk("steals", 16'(nown), 16'h0002);
		chk("byte0", got[0], 16'h00a5);
		rio(0, 8'h47, 8'h00, r);
		chk("start", {8'h00, r}, 16'h0000);
		$display("test steal done");
		// Both channels ask in the same cycle; channel 1 must be served first.
		first = 0;
		ncpl = 0;
		cfg(2'b00, 8'h38, 8'h01);
		cfg(2'b01, 8'hb0, 8'h01);
		go1 = 1;
		go2 = 1;
		for (int k = 0; k < 300 && ncpl < 2; k++) @(negedge i_clk);
		go1 = 0;
		go2 = 0;
		chk("first", 16'(first), 16'h0001);
		$display("test priority done");
		// External master owns the bus, then a busy address strobe delays our takeover.
		i_bus_request_n = 0;
		for (int k = 0; k < 20 && o_bus_grant_n; k++) @(negedge i_clk);
		chk("ext_grant", {15'h0000, o_bus_grant_n}, 16'h0000);
		i_bus_grant_ack_n = 0;
		i_address_strobe_n = 0;
		cfg(2'b00, 8'h38, 8'h01);
		go1 = 1;
		repeat (15) @(negedge i_clk);
		chk("wait_ext", {14'h0000, o_int_bus_request_n, o_bus_grant_n}, 16'h0003);
		i_bus_grant_ack_n = 1;
		i_bus_request_n = 1;
		repeat (20) @(negedge i_clk);
		chk("as_busy", {14'h0000, o_bus_owner, o_int_bus_request_n}, 16'h0000);
		i_address_strobe_n = 1;
		for (int k = 0; k < 30 && o_chan1_acknowledge_n; k++) @(negedge i_clk);
		chk("took_bus", {15'h0000, o_chan1_acknowledge_n}, 16'h0000);
		go1 = 0;
		$display("test arbitration done");
		// A second reset in mid-run clears the stored mode bits.
		repeat (10) @(negedge i_clk);
		i_nrst = 0;
		repeat (3) @(negedge i_clk);
		i_nrst = 1;
		rio(0, 8'h04, 8'h00, r);
		chk("dcr_reset", {8'h00, r}, 16'h0030);
		$display("test reset done");
		// Dual addressing on channel 2: the bus acknowledge paces it, the device acknowledge stays high.
		first = 0;
		ncpl = 0;
		cfg(2'b01, 8'h00, 8'h01);
		go2 = 1;
		for (int k = 0; k < 40 && !o_bus_owner; k++) @(negedge i_clk);
		i_data_transfer_ack_n = 0;
		for (int k = 0; k < 40 && ncpl < 1; k++) @(negedge i_clk);
		i_data_transfer_ack_n = 1;
		go2 = 0;
		chk("dual_cpl", 16'(ncpl), 16'h0001);
		chk("dual_ack", 16'(first), 16'h0000);
		$display("test dual done");
		close_out();
	end
endmodule // tb
